/* host_cpu.sv */
/*
  Host CPU model for the status register port: strobed writes and reads.
  Assumes callers wait for each task to return before the next access.
*/
`timescale 1ns/1ns
`default_nettype none
module host_cpu
  import irq_status_pkg::*;
(
  input wire logic clk_sys,
  output var host_access_t host,
  input wire logic [7:0] rdata
);
  initial host = '{sel: 1'b0, wr: 1'b0, addr: 4'hf, wdata: 8'h00};
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host <= '{sel: 1'b1, wr: 1'b1, addr: a, wdata: (a == off_msg_status) ? {d[7:5], 5'h0} : d};
    @(posedge clk_sys);
    // Released lines toggle so a stale value is never mistaken for a live one
    host <= '{sel: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host <= '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    host <= '{sel: 1'b0, wr: 1'b1, addr: ~a, wdata: 8'hff};
    #1 d = rdata;
  endtask
endmodule // host_cpu
`default_nettype wire

/* irq_source.sv */
/*
  One interrupt source: pending, enable and in-service flags changed by
  the 3-bit command, plus a hardware event that sets pending.
  Assumes commands and events are single-cycle pulses on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_source
  import irq_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd,
  input wire logic event_pulse,
  output source_bits_t bits,
  output logic request
);

  typedef struct packed {
    source_bits_t src;
  } state_t;

  state_t state;
  state_t next_state;

  always_comb begin
    next_state = state;
    if (cmd_valid) begin
      case (cmd)
        cmd_clr_pend_svc: begin
          next_state.src.pend = 1'b0;
          next_state.src.svc = 1'b0;
        end
        cmd_set_svc: next_state.src.svc = 1'b1;
        cmd_clr_svc: next_state.src.svc = 1'b0;
        cmd_set_pend: next_state.src.pend = 1'b1;
        cmd_clr_pend: next_state.src.pend = 1'b0;
        cmd_set_en: next_state.src.en = 1'b1;
        cmd_clr_en: next_state.src.en = 1'b0;
        default: next_state = state;
      endcase
    end
    // Hardware event wins over a clear in the same cycle
    if (event_pulse) begin
      next_state.src.pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '{src: source_reset};
    end else begin
      state <= next_state;
    end
  end

  assign bits = state.src;
  assign request = state.src.pend & state.src.en & ~state.src.svc;

endmodule // irq_source
`default_nettype wire

/* irq_status_pkg.sv */
/*
  Package for the per-source interrupt status block: register offsets,
  command codes, bit positions and reset values.
  Assumes a 4-bit register address and 8-bit data from the host port.
*/
package irq_status_pkg;

  localparam logic [3:0] off_msg_status = 4'h2;
  localparam logic [3:0] off_dir_match_status = 4'h3;
  localparam logic [3:0] off_second_group = 4'h4;
  localparam logic [3:0] off_full_empty_status = 4'h5;

  localparam logic [2:0] cmd_null = 3'h0;
  localparam logic [2:0] cmd_clr_pend_svc = 3'h1;
  localparam logic [2:0] cmd_set_svc = 3'h2;
  localparam logic [2:0] cmd_clr_svc = 3'h3;
  localparam logic [2:0] cmd_set_pend = 3'h4;
  localparam logic [2:0] cmd_clr_pend = 3'h5;
  localparam logic [2:0] cmd_set_en = 3'h6;
  localparam logic [2:0] cmd_clr_en = 3'h7;

  // Command field sits in the top three bits of each status register
  localparam int cmd_msb = 7;
  localparam int cmd_lsb = 5;

  // Low source of a register: svc, en, pend at bits 3..1; high source at 7..5, flag at bit 0
  localparam int lo_pend_bit = 1;
  localparam int lo_en_bit = 2;
  localparam int lo_svc_bit = 3;
  localparam int hi_pend_bit = 5;
  localparam int hi_en_bit = 6;
  localparam int hi_svc_bit = 7;
  localparam int flag_bit = 0;

  localparam logic [2:0] source_reset = 3'h0;

  typedef struct packed {
    logic pend;
    logic en;
    logic svc;
  } source_bits_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_access_t;

endpackage

/* irq_status_sources.sv */
/*
  Interrupt status registers for message, direction change, pattern
  match, buffer full and buffer empty sources of a byte FIFO unit.
  Assumes the host port is already decoded and synchronous to clk_sys,
  and that event inputs are single-cycle pulses from same-clock logic.
  The request answers two cycles after a source event and one cycle after
  a status-compare or error event, well inside one address-strobe cycle.
*/
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// - A 3-bit command sets or clears pending, enable and in-service bits.
// - Direction-change source lives in status register at address 0011.
// - Pattern-match source shares that register with direction change.
// - Read-only pattern-match flag shows a masked compare hit; writes ignored.
// - Buffer-full source lives in status register at address 0101.
// - Buffer-empty source and read-only empty bit share the full register.
// - Enabled far-side message write raises the request within one strobe.
// - Other enabled events raise the request within one strobe cycle.
// - Message source lives in status register at address 0010.
module irq_status_sources
  import irq_status_pkg::*;
#(
  parameter int data_width = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire host_access_t host,
  output logic [data_width-1:0] rdata,
  input wire logic msg_written,
  input wire logic dir_changed,
  input wire logic [data_width-1:0] compare_data,
  input wire logic [data_width-1:0] pattern,
  input wire logic [data_width-1:0] pattern_mask,
  input wire logic buffer_full_event,
  input wire logic buffer_empty_event,
  input wire logic buffer_empty,
  input wire logic status_compare_event,
  input wire logic error_event,
  output logic irq_request
);

  localparam int n_src = 5;
  localparam int src_msg = 0;
  localparam int src_dir = 1;
  localparam int src_match = 2;
  localparam int src_full = 3;
  localparam int src_empty = 4;

  typedef struct packed {
    logic [data_width-1:0] rdata;
    logic match_flag;
    logic match_prev;
    logic irq;
  } state_t;

  state_t state;
  state_t next_state;

  logic [n_src-1:0] cmd_valid;
  logic [n_src-1:0] events;
  logic [n_src-1:0] requests;
  source_bits_t src_bits [n_src];
  logic match_now;
  logic wr_cmd;
  logic [data_width-1:0] word_msg;
  logic [data_width-1:0] word_dir_match;
  logic [data_width-1:0] word_full_empty;

  assign wr_cmd = host.sel & host.wr;
  // Unused bits are expected zero from software; hardware ignores them
  assign match_now = ((compare_data ^ pattern) & ~pattern_mask) == '0;

  // Each register write reaches at most one source; bit 4 picks the high source
  always_comb begin
    cmd_valid = '0;
    if (wr_cmd) begin
      case (host.addr)
        off_msg_status: begin
          cmd_valid[src_msg] = 1'b1;
        end
        off_dir_match_status: begin
          if (host.wdata[4]) begin
            cmd_valid[src_dir] = 1'b1;
          end else begin
            cmd_valid[src_match] = 1'b1;
          end
        end
        off_full_empty_status: begin
          if (host.wdata[4]) begin
            cmd_valid[src_full] = 1'b1;
          end else begin
            cmd_valid[src_empty] = 1'b1;
          end
        end
        // The second group register holds no source here, so its writes fall away
        default: cmd_valid = '0;
      endcase
    end
  end

  always_comb begin
    events = '0;
    events[src_msg] = msg_written;
    events[src_dir] = dir_changed;
    // Only a fresh match pends; a held match would re-pend after every clear
    events[src_match] = match_now & ~state.match_prev;
    events[src_full] = buffer_full_event;
    events[src_empty] = buffer_empty_event;
  end

  // All sources share the command field; only the selected one acts on it
  irq_source u_src_msg (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid[src_msg]),
    .cmd(host.wdata[cmd_msb:cmd_lsb]),
    .event_pulse(events[src_msg]),
    .bits(src_bits[src_msg]),
    .request(requests[src_msg])
  );

  irq_source u_src_dir (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid[src_dir]),
    .cmd(host.wdata[cmd_msb:cmd_lsb]),
    .event_pulse(events[src_dir]),
    .bits(src_bits[src_dir]),
    .request(requests[src_dir])
  );

  irq_source u_src_match (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid[src_match]),
    .cmd(host.wdata[cmd_msb:cmd_lsb]),
    .event_pulse(events[src_match]),
    .bits(src_bits[src_match]),
    .request(requests[src_match])
  );

  irq_source u_src_full (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid[src_full]),
    .cmd(host.wdata[cmd_msb:cmd_lsb]),
    .event_pulse(events[src_full]),
    .bits(src_bits[src_full]),
    .request(requests[src_full])
  );

  irq_source u_src_empty (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid[src_empty]),
    .cmd(host.wdata[cmd_msb:cmd_lsb]),
    .event_pulse(events[src_empty]),
    .bits(src_bits[src_empty]),
    .request(requests[src_empty])
  );

  // Read words are built apart from the mux so each layout stands on its own
  always_comb begin
    word_msg = '0;
    word_msg[lo_pend_bit] = src_bits[src_msg].pend;
    word_msg[lo_en_bit] = src_bits[src_msg].en;
    word_msg[lo_svc_bit] = src_bits[src_msg].svc;
  end

  always_comb begin
    word_dir_match = '0;
    word_dir_match[flag_bit] = state.match_flag;
    word_dir_match[lo_pend_bit] = src_bits[src_match].pend;
    word_dir_match[lo_en_bit] = src_bits[src_match].en;
    word_dir_match[lo_svc_bit] = src_bits[src_match].svc;
    word_dir_match[hi_pend_bit] = src_bits[src_dir].pend;
    word_dir_match[hi_en_bit] = src_bits[src_dir].en;
    word_dir_match[hi_svc_bit] = src_bits[src_dir].svc;
  end

  always_comb begin
    word_full_empty = '0;
    word_full_empty[flag_bit] = buffer_empty;
    word_full_empty[lo_pend_bit] = src_bits[src_empty].pend;
    word_full_empty[lo_en_bit] = src_bits[src_empty].en;
    word_full_empty[lo_svc_bit] = src_bits[src_empty].svc;
    word_full_empty[hi_pend_bit] = src_bits[src_full].pend;
    word_full_empty[hi_en_bit] = src_bits[src_full].en;
    word_full_empty[hi_svc_bit] = src_bits[src_full].svc;
  end

  always_comb begin
    next_state = state;
    next_state.match_flag = match_now;
    next_state.match_prev = match_now;
    next_state.irq = |requests;
    next_state.rdata = '0;
    if (host.sel && !host.wr) begin
      case (host.addr)
        off_msg_status: next_state.rdata = word_msg;
        off_dir_match_status: next_state.rdata = word_dir_match;
        off_full_empty_status: next_state.rdata = word_full_empty;
        // Unmapped and second-group addresses read as zero
        default: next_state.rdata = '0;
      endcase
    end
    // Status-compare and error have no status bits in this block
    if (status_compare_event || error_event) begin
      next_state.irq = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign irq_request = state.irq;

endmodule // irq_status_sources
`default_nettype wire

/* irq_status_sources_asserts.sv */
/*
  Checker for the status block: read data timing and request behaviour.
  Assumes it is bound to irq_status_sources by the bind at the foot.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_status_sources_asserts
  import irq_status_pkg::*;
#(
  parameter int data_width = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire host_access_t host,
  input wire logic [data_width-1:0] rdata,
  input wire logic buffer_empty,
  input wire logic status_compare_event,
  input wire logic error_event,
  input wire logic irq_request
);
  logic [5:0] hist;
  logic rd;
  assign rd = host.sel && !host.wr;
  // A request can only drop after a command or the end of a pulse source
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hist <= '0;
    end else begin
      hist <= {hist[4:0], host.sel | status_compare_event | error_event};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !irq_request && rdata == '0)
    else $error("outputs not quiet after reset");
  unmapped_read_a: assert property (rd && !(host.addr inside {4'h2, 4'h3, 4'h5}) |=> rdata == '0)
    else $error("unmapped read gave data");
  msg_unused_a: assert property (rd && host.addr == off_msg_status |=> rdata[7:4] == 4'h0 && !rdata[0])
    else $error("message register unused bits set");
  bit4_zero_a: assert property (rd && host.addr inside {4'h3, 4'h5} |=> !rdata[4])
    else $error("unused bit 4 read as one");
  empty_bit_a: assert property (rd && host.addr == off_full_empty_status |=> rdata[0] == $past(buffer_empty))
    else $error("empty status bit wrong");
  compare_pulse_a: assert property (status_compare_event |-> ##[1:3] irq_request)
    else $error("no request after compare event");
  error_pulse_a: assert property (error_event |-> ##[1:3] irq_request)
    else $error("no request after error event");
  request_drop_a: assert property ($fell(irq_request) |-> |hist)
    else $error("request dropped without cause");
endmodule // irq_status_sources_asserts
bind irq_status_sources irq_status_sources_asserts #(.data_width(data_width)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .host(host), .rdata(rdata), .buffer_empty(buffer_empty),
  .status_compare_event(status_compare_event), .error_event(error_event),
  .irq_request(irq_request));
`default_nettype wire

/* irq_status_sources_tb.sv */
/*
  Bench for the status block: every command code in turn on random sources, plus random events, against a model.
  Assumes host_cpu drives the register port and the checker is bound.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module irq_status_sources_tb
  import irq_status_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  host_access_t host;
  logic [7:0] rdata, d, cd = 8'h00, mask = 8'h00, pat = 8'h5a;
  logic [3:0] ev = 4'h0, a;
  logic sc = 1'b0, er = 1'b0, be = 1'b0, irq, mt = 1'b0, nm;
  logic [4:0] p = 5'h0, e = 5'h0, s = 5'h0;
  logic [31:0] r = 32'hce4447ac;
  int miscompares = 0, num_checks = 0, i, src, cmd;
  host_cpu u_host (.clk_sys(clk_sys), .host(host), .rdata(rdata));
  irq_status_sources u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .host(host), .rdata(rdata),
    .msg_written(ev[0]), .dir_changed(ev[1]), .compare_data(cd), .pattern(pat),
    .pattern_mask(mask), .buffer_full_event(ev[2]), .buffer_empty_event(ev[3]),
    .buffer_empty(be), .status_compare_event(sc), .error_event(er), .irq_request(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_reg(input logic [3:0] ad);
    case (ad)
      4'h2: return {4'h0, s[0], e[0], p[0], 1'b0};
      4'h3: return {s[1], e[1], p[1], 1'b0, s[2], e[2], p[2], mt};
      default: return {s[3], e[3], p[3], 1'b0, s[4], e[4], p[4], be};
    endcase
  endfunction
  task automatic close_out;
    $display("checks %0d, wrong %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #20000;
    miscompares++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 48; i++) begin
      r = lfsr(r);
      cmd = i % 8;
      src = r[2:0] % 5;
      a = (src == 0) ? off_msg_status : (src < 3) ? off_dir_match_status : off_full_empty_status;
      u_host.wr(a, {cmd[2:0], src == 1 || src == 3, 4'h0});
      case (cmd)
        1: begin p[src] = 1'b0; s[src] = 1'b0; end
        2: s[src] = 1'b1;
        3: s[src] = 1'b0;
        4: p[src] = 1'b1;
        5: p[src] = 1'b0;
        6: e[src] = 1'b1;
        7: e[src] = 1'b0;
        default: ;
      endcase
      @(posedge clk_sys);
      ev <= r[7:4];
      sc <= r[8];
      er <= r[9];
      be <= r[10];
      cd <= r[23:16];
      pat <= r[15:8];
      mask <= r[31:24] | 8'h3c;
      @(posedge clk_sys);
      ev <= 4'h0;
      sc <= 1'b0;
      er <= 1'b0;
      p = p | {r[7:6], 1'b0, r[5:4]};
      nm = ((r[23:16] ^ r[15:8]) & ~(r[31:24] | 8'h3c)) == 8'h00;
      if (nm && !mt) p[2] = 1'b1;
      mt = nm;
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK(irq, |(p & e & ~s))
      u_host.rd(a, d);
      `CHK(d, exp_reg(a))
    end
    $display("random command test done");
    u_host.rd(4'h4, d);
    `CHK(d, 8'h00)
    $display("unmapped read test done");
    close_out;
  end
endmodule // irq_status_sources_tb
`default_nettype wire
